// [sas_defs.vh]
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// register byte offsets
`define SAS_OFF_CMD        8'h00
`define SAS_OFF_CFG        8'h04
`define SAS_OFF_IN_EN      8'h10
`define SAS_OFF_IN_DIS     8'h14
`define SAS_OFF_IN_STATE   8'h18
`define SAS_OFF_FLAGS      8'h20
`define SAS_OFF_IRQ_EN     8'h24
`define SAS_OFF_IRQ_DIS    8'h28
`define SAS_OFF_IRQ_MASK   8'h2c
`define SAS_OFF_RESULT0    8'h30
`define SAS_OFF_RESULT1    8'h34
`define SAS_OFF_RESULT2    8'h38
`define SAS_OFF_RESULT3    8'h3c

// control_command fields
`define SAS_CMD_SOFT_RESET 0
`define SAS_CMD_START      1

// operating_config fields
`define SAS_CFG_TRG_EN     0
`define SAS_CFG_TRG_LO     1
`define SAS_CFG_TRG_HI     3
`define SAS_CFG_EIGHT_BIT  4
`define SAS_CFG_SLEEP      5
`define SAS_CFG_DIV_LO     8
`define SAS_CFG_DIV_HI     13
`define SAS_CFG_RESET      14'h0000

// flag_status / irq mask layout
`define SAS_FLG_DONE_LO    0
`define SAS_FLG_DONE_HI    3
`define SAS_FLG_OVR_LO     8
`define SAS_FLG_OVR_HI     11

// trigger source codes
`define SAS_TRG_EXTERNAL   3'h6
`define SAS_TRG_RESERVED   3'h7

// timing
`define SAS_CONV_CYCLES    4'hb
`define SAS_CLK_KHZ        40000
`define SAS_STARTUP_NS     20000
`define SAS_STARTUP_CYC    ((`SAS_STARTUP_NS * `SAS_CLK_KHZ + 999999) / 1000000)

// sequencer states
`define SAS_ST_IDLE        2'h0
`define SAS_ST_WAKE        2'h1
`define SAS_ST_CONV        2'h2

`endif

// [sas_clkdiv.v]
`timescale 1ns/1ps
`include "sas_defs.vh"

// converter clock: master clock / (div + 1) / 2, restarted whenever run drops
module sas_clkdiv #(
	parameter DIV_W = 6
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire             run,
	input  wire [DIV_W-1:0] div,
	output wire             conv_clk,
	output wire             conv_rise
);
	reg [DIV_W-1:0] count_q;
	reg             phase_q;
	wire            wrap;

	assign wrap      = run && (count_q == div);
	assign conv_rise = wrap && !phase_q;
	assign conv_clk  = phase_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= {DIV_W{1'b0}};
			phase_q <= 1'b0;
		end else if (!run) begin
			count_q <= {DIV_W{1'b0}};
			phase_q <= 1'b0;
		end else if (wrap) begin
			count_q <= {DIV_W{1'b0}};
			phase_q <= ~phase_q;
		end else begin
			count_q <= count_q + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// [sas_adc_seq.v]
// What this block does
// - each conversion takes eleven converter clock cycles
// - converter clock is master/(divider+1)/2
// - completion stores result and sets done flag
// - reading a result clears its done flag
// - unread result overwritten sets overrun flag
// - ten-bit after reset; eight-bit zeroes top bits
// - start bit begins sequence, clears done flags
// - soft reset bit resets whole block
// - hardware trigger accepted only when enabled
// - source codes: timers 0-5, external, reserved
// - rising edge of selected trigger starts sequence
// - one request converts all enabled inputs once
// - enable/disable registers set or clear inputs
// - sleep keeps core off while idle, wakes
// - result loads only while input is enabled
// - input state register shows enable bits
// - reading status clears overrun flags
// - interrupt when masked done or overrun set
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "sas_defs.vh"

module sas_adc_seq #(
	parameter NUM_IN      = 4,
	parameter DIV_W       = 6,
	parameter DATA_W      = 10,
	parameter STARTUP_CYC = `SAS_STARTUP_CYC
) (
	input  wire              clk,
	input  wire              reset_n,
	input  wire [7:0]        addr,
	input  wire [31:0]       wdata,
	input  wire              wr_en,
	input  wire              rd_en,
	output reg  [31:0]       rdata,
	input  wire [5:0]        timer_wave_output,
	input  wire              external_trigger_0,
	input  wire [DATA_W-1:0] core_result,
	output reg               core_power,
	output reg               core_convert,
	output reg  [1:0]        core_input_sel,
	output wire              core_clk,
	output wire              irq
);
	// register strobes
	wire wr_cmd;
	wire wr_cfg;
	wire wr_in_en;
	wire wr_in_dis;
	wire wr_irq_en;
	wire wr_irq_dis;
	wire rd_flags;
	wire soft_rst;
	wire sw_start;

	assign wr_cmd     = wr_en && (addr == `SAS_OFF_CMD);
	assign wr_cfg     = wr_en && (addr == `SAS_OFF_CFG);
	assign wr_in_en   = wr_en && (addr == `SAS_OFF_IN_EN);
	assign wr_in_dis  = wr_en && (addr == `SAS_OFF_IN_DIS);
	assign wr_irq_en  = wr_en && (addr == `SAS_OFF_IRQ_EN);
	assign wr_irq_dis = wr_en && (addr == `SAS_OFF_IRQ_DIS);
	assign rd_flags   = rd_en && (addr == `SAS_OFF_FLAGS);
	assign soft_rst   = wr_cmd && wdata[`SAS_CMD_SOFT_RESET];
	assign sw_start   = wr_cmd && wdata[`SAS_CMD_START];

	// lowest enabled input at or above a given index
	function [2:0] pick_input;
		input [3:0] en;
		input [2:0] from;
		integer     i;
		reg         found;
		begin
			found      = 1'b0;
			pick_input = 3'h4;
			for (i = 0; i < 4; i = i + 1) begin
				if (!found && en[i] && (i >= from)) begin
					found      = 1'b1;
					pick_input = i[2:0];
				end
			end
		end
	endfunction

	// result read strobe for one input
	function rd_result;
		input [7:0] a;
		input       rd;
		input [1:0] n;
		begin
			rd_result = rd && (a == (`SAS_OFF_RESULT0 + {4'h0, n, 2'h0}));
		end
	endfunction

	// configuration
	reg  [13:0]       cfg_q;
	reg  [3:0]        in_en_q;
	reg  [11:0]       mask_q;
	wire              trg_en;
	wire [2:0]        trg_src;
	wire              eight_bit;
	wire              sleep;
	wire [DIV_W-1:0]  div;

	assign trg_en    = cfg_q[`SAS_CFG_TRG_EN];
	assign trg_src   = cfg_q[`SAS_CFG_TRG_HI:`SAS_CFG_TRG_LO];
	assign eight_bit = cfg_q[`SAS_CFG_EIGHT_BIT];
	assign sleep     = cfg_q[`SAS_CFG_SLEEP];
	assign div       = cfg_q[`SAS_CFG_DIV_HI:`SAS_CFG_DIV_LO];

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q   <= `SAS_CFG_RESET;
			in_en_q <= 4'h0;
			mask_q  <= 12'h000;
		end else if (soft_rst) begin
			cfg_q   <= `SAS_CFG_RESET;
			in_en_q <= 4'h0;
			mask_q  <= 12'h000;
		end else begin
			if (wr_cfg)
				cfg_q <= wdata[13:0];
			if (wr_in_en)
				in_en_q <= in_en_q | wdata[3:0];
			if (wr_in_dis)
				in_en_q <= in_en_q & ~wdata[3:0];
			if (wr_irq_en)
				mask_q <= mask_q | wdata[11:0];
			if (wr_irq_dis)
				mask_q <= mask_q & ~wdata[11:0];
		end
	end

	// hardware trigger selection and edge detection
	reg  trg_sel_sig;
	reg  trg_prev_q;
	wire hw_start;

	always @* begin
		if (trg_src == `SAS_TRG_EXTERNAL) begin
			trg_sel_sig = external_trigger_0;
		end else if (trg_src == `SAS_TRG_RESERVED) begin
			trg_sel_sig = 1'b0;
		end else begin
			trg_sel_sig = timer_wave_output[trg_src];
		end
	end

	// edge taken against last cycle's level, so switch sources only while both are low
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			trg_prev_q <= 1'b0;
		else if (soft_rst)
			trg_prev_q <= 1'b0;
		else
			trg_prev_q <= trg_sel_sig;
	end

	assign hw_start = trg_en && trg_sel_sig && !trg_prev_q;

	// sequencer
	reg  [1:0]  state_q;
	reg  [1:0]  chan_q;
	reg  [3:0]  cyc_q;
	reg  [15:0] wake_q;
	wire        start_req;
	wire        conv_rise;
	wire        conv_end;
	wire [2:0]  first_in;
	wire [2:0]  next_in;

	// first converter rise comes half a period after the start, later ones a full period apart
	assign start_req = sw_start || hw_start;
	assign first_in  = pick_input(in_en_q, 3'h0);
	assign next_in   = pick_input(in_en_q, {1'b0, chan_q} + 3'h1);
	assign conv_end  = (state_q == `SAS_ST_CONV) && conv_rise &&
	                   (cyc_q == `SAS_CONV_CYCLES - 4'h1);

	sas_clkdiv #(
		.DIV_W (DIV_W)
	) u_div (
		.clk       (clk),
		.reset_n   (reset_n),
		.run       (state_q == `SAS_ST_CONV),
		.div       (div),
		.conv_clk  (core_clk),
		.conv_rise (conv_rise)
	);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= `SAS_ST_IDLE;
			chan_q  <= 2'h0;
			cyc_q   <= 4'h0;
			wake_q  <= 16'h0000;
		end else if (soft_rst) begin
			state_q <= `SAS_ST_IDLE;
			chan_q  <= 2'h0;
			cyc_q   <= 4'h0;
			wake_q  <= 16'h0000;
		end else begin
			case (state_q)
			`SAS_ST_IDLE: begin
				cyc_q <= 4'h0;
				// a start outside idle is dropped; a software start still clears the done flags
				if (start_req && !first_in[2]) begin
					chan_q <= first_in[1:0];
					if (sleep) begin
						wake_q  <= 16'h0000;
						state_q <= `SAS_ST_WAKE;
					end else begin
						state_q <= `SAS_ST_CONV;
					end
				end
			end
			`SAS_ST_WAKE: begin
				if (wake_q == STARTUP_CYC[15:0] - 16'h0001)
					state_q <= `SAS_ST_CONV;
				else
					wake_q <= wake_q + 16'h0001;
			end
			`SAS_ST_CONV: begin
				if (conv_rise) begin
					if (conv_end) begin
						cyc_q <= 4'h0;
						if (next_in[2]) begin
							state_q <= `SAS_ST_IDLE;
						end else begin
							// stay converting; the divider runs on into the next input
							chan_q  <= next_in[1:0];
							state_q <= `SAS_ST_CONV;
						end
					end else begin
						cyc_q <= cyc_q + 4'h1;
					end
				end
			end
			default: begin
				state_q <= `SAS_ST_IDLE;
			end
			endcase
		end
	end

	// analogue core controls
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core_power     <= 1'b0;
			core_convert   <= 1'b0;
			core_input_sel <= 2'h0;
		end else begin
			core_power     <= !soft_rst && (!sleep || (state_q != `SAS_ST_IDLE));
			core_convert   <= !soft_rst && (state_q == `SAS_ST_CONV) && !conv_end;
			core_input_sel <= chan_q;
		end
	end

	// results and flags
	reg  [DATA_W-1:0] result_q [0:NUM_IN-1];
	reg  [3:0]        done_q;
	reg  [3:0]        ovr_q;
	reg  [3:0]        rd_res;
	reg  [3:0]        unread_q;
	wire [DATA_W-1:0] conv_val;
	integer           k;
	integer           j;

	assign conv_val = eight_bit ? {2'h0, core_result[7:0]} : core_result;

	always @* begin
		for (k = 0; k < NUM_IN; k = k + 1)
			rd_res[k] = rd_result(addr, rd_en, k[1:0]);
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			done_q   <= 4'h0;
			ovr_q    <= 4'h0;
			unread_q <= 4'h0;
			for (j = 0; j < NUM_IN; j = j + 1)
				result_q[j] <= {DATA_W{1'b0}};
		end else if (soft_rst) begin
			done_q   <= 4'h0;
			ovr_q    <= 4'h0;
			unread_q <= 4'h0;
			for (j = 0; j < NUM_IN; j = j + 1)
				result_q[j] <= {DATA_W{1'b0}};
		end else begin
			for (j = 0; j < NUM_IN; j = j + 1) begin
				if (conv_end && (chan_q == j[1:0]) && in_en_q[j]) begin
					result_q[j] <= conv_val;
					done_q[j]   <= 1'b1;
					unread_q[j] <= 1'b1;
					// a start clears done but not unread, so skipped results still overrun
					if (unread_q[j] && !rd_res[j])
						ovr_q[j] <= 1'b1;
					else if (rd_flags)
						ovr_q[j] <= 1'b0;
				end else begin
					if (sw_start || rd_res[j])
						done_q[j] <= 1'b0;
					if (rd_res[j])
						unread_q[j] <= 1'b0;
					if (rd_flags)
						ovr_q[j] <= 1'b0;
				end
			end
		end
	end

	// interrupt from masked flags
	wire [11:0] flags;

	assign flags = {ovr_q, 4'h0, done_q};
	assign irq   = |(flags & mask_q);

	// read data, one cycle after the read strobe
	reg [31:0] rd_mux;

	always @* begin
		case (addr)
		`SAS_OFF_CFG:      rd_mux = {18'h00000, cfg_q};
		`SAS_OFF_IN_STATE: rd_mux = {28'h0000000, in_en_q};
		`SAS_OFF_FLAGS:    rd_mux = {20'h00000, flags};
		`SAS_OFF_IRQ_MASK: rd_mux = {20'h00000, mask_q};
		`SAS_OFF_RESULT0:  rd_mux = {22'h000000, result_q[0]};
		`SAS_OFF_RESULT1:  rd_mux = {22'h000000, result_q[1]};
		`SAS_OFF_RESULT2:  rd_mux = {22'h000000, result_q[2]};
		`SAS_OFF_RESULT3:  rd_mux = {22'h000000, result_q[3]};
		default:           rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata <= 32'h00000000;
		else if (rd_en)
			rdata <= rd_mux;
		else
			rdata <= 32'h00000000;
	end
endmodule

// [sas_core_model.sv]
`timescale 1ns/1ps
module sas_core_model (
	input  wire logic       clk,
	input  wire logic       core_power,
	input  wire logic       core_convert,
	input  wire logic [1:0] core_input_sel,
	output logic      [9:0] core_result = 10'h155
);
	// outside a conversion the lines wander, so a stale sample shows up
	always @(posedge clk) begin
		if (core_power && core_convert)
			core_result <= 10'h2c0 + 10'(core_input_sel);
		else
			core_result <= ~core_result;
	end
endmodule

// [sas_adc_seq_sva.sv]
`timescale 1ns/1ps
module sas_adc_seq_sva (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [31:0] rdata,
	input wire logic        core_power,
	input wire logic        core_convert,
	input wire logic [1:0]  core_input_sel,
	input wire logic        core_clk,
	input wire logic        irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	a_clk_quiet: assert property (!core_convert && !$past(core_convert) |-> !core_clk)
		else $error("converter clock runs while idle");
	a_sel_order: assert property (
		core_convert && !$past(core_convert) && $past(core_convert, 2)
		|-> core_input_sel > $past(core_input_sel, 2))
		else $error("inputs converted out of order");
	a_conv_power: assert property (core_convert |-> core_power)
		else $error("conversion with core unpowered");
	a_soft_reset: assert property (wr_en && addr == 8'h00 && wdata[0] |=>
		!core_convert && !core_power && !irq)
		else $error("soft reset left block active");
	a_state_bits: assert property (rd_en && addr == 8'h18 |=> rdata[31:4] == 28'h0)
		else $error("input state upper bits set");
	a_result_top: assert property (rd_en && addr[7:4] == 4'h3 |=> rdata[31:10] == 22'h0)
		else $error("result upper bits set");
	a_flag_bits: assert property (rd_en && addr == 8'h20 |=>
		rdata[31:12] == 20'h0 && rdata[7:4] == 4'h0)
		else $error("status reserved bits set");
	a_irq_off: assert property (wr_en && addr == 8'h28 && wdata[11:0] == 12'hfff |=> !irq)
		else $error("interrupt with all sources masked");
	c_last_input: cover property (core_convert && core_input_sel == 2'h3);
	c_irq_rise: cover property ($rose(irq));
	c_soft_reset: cover property (wr_en && addr == 8'h00 && wdata[0]);
endmodule

bind sas_adc_seq sas_adc_seq_sva sas_adc_seq_sva_inst (
	.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .core_power(core_power), .core_convert(core_convert),
	.core_input_sel(core_input_sel), .core_clk(core_clk), .irq(irq)
);

// [sas_adc_seq_test.sv]
`timescale 1ns/1ps
module sas_adc_seq_test;
	logic        clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, external_trigger_0 = 0;
	logic [7:0]  addr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [5:0]  timer_wave_output = 0;
	logic        core_power, core_convert, core_clk, irq;
	logic [1:0]  core_input_sel;
	logic [9:0]  core_result;
	int          bad_count, checked, n, i, t;
	typedef struct {bit w; logic [7:0] a; logic [31:0] d;} sas_row_t;
	sas_row_t rows[19] = '{'{0, 8'h04, 0}, '{0, 8'h18, 0}, '{0, 8'h2c, 0}, '{0, 8'h30, 0},
		'{0, 8'h20, 0}, '{1, 8'h10, 5}, '{0, 8'h18, 5}, '{1, 8'h14, 4}, '{0, 8'h18, 1},
		'{1, 8'h24, 32'hf0f}, '{1, 8'h28, 32'hf00}, '{0, 8'h2c, 32'hf}, '{1, 8'h04, 32'h3f3e},
		'{0, 8'h04, 32'h3f3e}, '{1, 8'h18, 32'hf}, '{0, 8'h18, 1}, '{0, 8'h08, 0},
		'{0, 8'h00, 0}, '{0, 8'h10, 0}};

	sas_adc_seq #(.STARTUP_CYC(4)) sas_adc_seq_inst (.clk(clk), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.timer_wave_output(timer_wave_output), .external_trigger_0(external_trigger_0),
		.core_result(core_result), .core_power(core_power), .core_convert(core_convert),
		.core_input_sel(core_input_sel), .core_clk(core_clk), .irq(irq));
	sas_core_model sas_core_model_inst (.clk(clk), .core_power(core_power),
		.core_convert(core_convert), .core_input_sel(core_input_sel),
		.core_result(core_result));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp(logic [31:0] g, logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr_en <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge clk);
		rd_en <= 1;
		addr <= a;
		@(posedge clk);
		rd_en <= 0;
		#1;
		cmp(rdata, e);
	endtask

	// waits for a conversion to begin, then for the whole sequence to go idle
	task automatic run(bit e);
		t = 0;
		for (n = 0; n < 40 && core_convert !== 1'b1; n++)
			@(negedge clk);
		cmp(core_convert, e);
		// core_convert dips for one cycle between inputs: idle means three low samples
		n = 0;
		while (n < 3 && t < 2000) begin
			@(negedge clk);
			t++;
			n = (core_convert === 1'b1) ? 0 : n + 1;
		end
		if (n < 3) begin
			bad_count++;
			print_verdict();
		end
	endtask

	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1;
		foreach (rows[k]) begin
			if (rows[k].w)
				wr(rows[k].a, rows[k].d);
			else
				rd(rows[k].a, rows[k].d);
		end
		$display("test registers done");
		wr(8'h04, 32'h1200);
		wr(8'h10, 32'hf);
		wr(8'h24, 32'hf);
		wr(8'h00, 32'h2);
		run(1);
		cmp(core_power, 1);
		rd(8'h20, 32'hf);
		for (i = 0; i < 4; i++)
			rd(8'(8'h30 + 4 * i), 32'h2c0 + i);
		cmp(irq, 0);
		rd(8'h20, 0);
		wr(8'h00, 32'h2);
		run(1);
		wr(8'h00, 32'h2);
		run(1);
		cmp(irq, 1);
		rd(8'h20, 32'hf0f);
		rd(8'h20, 32'hf);
		wr(8'h00, 32'h2);
		rd(8'h20, 0);
		run(1);
		rd(8'h20, 32'hf0f);
		$display("test sequence done");
		wr(8'h14, 32'he);
		wr(8'h04, 32'h1210);
		rd(8'h30, 32'h2c0);
		wr(8'h00, 32'h2);
		run(1);
		// divider 18: first rise after 19 clocks, ten periods of 38, then three idle samples
		cmp(t >= 398 && t <= 402, 1);
		rd(8'h30, 32'hc0);
		$display("test timing done");
		for (i = 0; i < 9; i++) begin
			wr(8'h04, 32'h1200 | ((i & 7) << 1) | (i < 8));
			rd(8'h30, i ? 32'h2c0 : 32'hc0);
			@(posedge clk);
			{external_trigger_0, timer_wave_output} <= (i == 7) ? 7'h7f : 7'(1 << (i & 7));
			repeat (2) @(posedge clk);
			{external_trigger_0, timer_wave_output} <= 7'h0;
			run(i < 7);
			rd(8'h20, i < 7);
		end
		$display("test triggers done");
		wr(8'h00, 32'h2);
		wr(8'h14, 32'h1);
		run(1);
		rd(8'h20, 0);
		wr(8'h10, 32'h1);
		wr(8'h04, 32'h1220);
		repeat (3) @(posedge clk);
		cmp(core_power, 0);
		wr(8'h00, 32'h2);
		run(1);
		@(negedge clk);
		cmp(core_power, 0);
		cmp(irq, 1);
		wr(8'h28, 32'hfff);
		@(negedge clk);
		cmp(irq, 0);
		wr(8'h00, 32'h1);
		rd(8'h04, 0);
		rd(8'h18, 0);
		rd(8'h30, 0);
		$display("test sleep and soft reset done");
		print_verdict();
	end
endmodule
